// *** include/ucg_map.vh ***
// Register map, field positions and constants of the serial clock and buffer core
`ifndef UCG_MAP_VH
`define UCG_MAP_VH

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define UCG_OFF_DATA    5'h00
`define UCG_OFF_STA     5'h04
`define UCG_OFF_CTB     5'h08
`define UCG_OFF_CTC     5'h0c
`define UCG_OFF_BDL     5'h10
`define UCG_OFF_BDH     5'h14

// ---------------------------------------------
// control_status_a fields
// ---------------------------------------------
`define UCG_STA_RXC     7
`define UCG_STA_TXC     6
`define UCG_STA_TXE     5
`define UCG_STA_FE      4
`define UCG_STA_OVR     3
`define UCG_STA_PERR    2
`define UCG_STA_DS      1

// ---------------------------------------------
// control_b fields
// ---------------------------------------------
`define UCG_CTB_RXIE    7
`define UCG_CTB_TXCIE   6
`define UCG_CTB_TXEIE   5
`define UCG_CTB_RXEN    4
`define UCG_CTB_TXEN    3
`define UCG_CTB_SZMSB   2
`define UCG_CTB_RX_NINTH_BIT    1
`define UCG_CTB_TXB8    0

// ---------------------------------------------
// control_status_c fields
// ---------------------------------------------
`define UCG_CTC_DIR     9
`define UCG_CTC_COMPAT  8
`define UCG_CTC_SYNC    6
`define UCG_CTC_PEN     5
`define UCG_CTC_PODD    4
`define UCG_CTC_STOP2   3
`define UCG_CTC_SZ_HI   2
`define UCG_CTC_SZ_LO   1
`define UCG_CTC_POL     0
`define UCG_CTC_RST     10'h006

// ---------------------------------------------
// Divide ratios and sizes
// ---------------------------------------------
`define UCG_OVS_NORM    4'hf
`define UCG_OVS_DBL     4'h7
`define UCG_MID_NORM    4'h7
`define UCG_MID_DBL     4'h3
`define UCG_NBITS_BASE  4'h5
`define UCG_NBITS_MAX   4'h9
`define UCG_FIFO_CAP    2'h2
`define UCG_FIFO_CAP_C  2'h1

`endif

// *** hdl/ucg_core.v ***
// Serial clock generator, transmit buffer and receive FIFO with Avalon-MM registers
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`include "ucg_map.vh"
`timescale 1ns/1ns
`default_nettype none

module ucg_core (
  input  wire        mclk_in,
  input  wire        rst_n_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire        rxd_in,
  output wire        txd_out,
  input  wire        xfer_clock_pin_in,
  output wire        xfer_clock_pin_out,
  output wire        xfer_clock_pin_oe_out,
  output wire        rx_done_irq_out,
  output wire        tx_empty_irq_out,
  output wire        tx_done_irq_out
);

  // ---------------------------------------------
  // Receiver states
  // ---------------------------------------------
  localparam [3:0] RX_IDLE = 4'h1;
  localparam [3:0] RX_DATA = 4'h2;
  localparam [3:0] RX_PAR  = 4'h4;
  localparam [3:0] RX_STOP = 4'h8;

  function ucg_parity;
    input [8:0] d;
    input [3:0] n;
    input       odd;
    reg   [8:0] m;
    begin
      m = ~(9'h1ff << n);
      ucg_parity = (^(d & m)) ^ odd;
    end
  endfunction

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  reg  [31:0] rdata_ff;
  reg         wait_ff;
  reg  [7:0]  ctb_ff;
  reg  [9:0]  ctc_ff;
  reg         ds_ff;
  reg  [7:0]  bdl_ff;
  reg  [3:0]  bdh_ff;
  reg  [11:0] baud_cnt_ff;
  reg         xck_ff;
  reg         xck_oe_ff;
  reg         xs1_ff;
  reg         xs2_ff;
  reg         xs3_ff;
  reg  [3:0]  tx_div_ff;
  reg  [8:0]  tx_buf_ff;
  reg         tx_full_ff;
  reg  [12:0] tx_sh_ff;
  reg  [3:0]  tx_left_ff;
  reg         tx_busy_ff;
  reg         txd_ff;
  reg         txc_ff;
  reg  [3:0]  rx_st_ff;
  reg  [3:0]  rx_ph_ff;
  reg  [3:0]  rx_cnt_ff;
  reg  [8:0]  rx_sh_ff;
  reg         rx_perr_ff;
  reg  [10:0] hold_ff;
  reg         hold_v_ff;
  reg         ovr_pend_ff;
  reg  [11:0] fifo_mem [0:1];
  reg         wr_ptr_ff;
  reg         rd_ptr_ff;
  reg  [1:0]  fifo_cnt_ff;
  reg         irq_rx_ff;
  reg         irq_txe_ff;
  reg         irq_txc_ff;

  // ---------------------------------------------
  // Bus decode
  // ---------------------------------------------
  wire        req   = avs_read_in | avs_write_in;
  wire        acc   = req & ~wait_ff;
  wire        wr    = acc & avs_write_in;
  wire        rd    = acc & avs_read_in;
  wire [4:0]  a     = avs_address_in;
  wire [31:0] wd    = avs_writedata_in;
  wire        wr_dat = wr & (a == `UCG_OFF_DATA);
  wire        wr_bdl = wr & (a == `UCG_OFF_BDL);
  wire        rd_dat = rd & (a == `UCG_OFF_DATA);

  // ---------------------------------------------
  // Mode decode
  // ---------------------------------------------
  wire is_sync   = ctc_ff[`UCG_CTC_SYNC];
  wire is_master = is_sync & ctc_ff[`UCG_CTC_DIR];
  wire is_slave  = is_sync & ~ctc_ff[`UCG_CTC_DIR];
  wire dbl       = ds_ff & ~is_sync;
  wire [3:0] ovs_last = dbl ? `UCG_OVS_DBL : `UCG_OVS_NORM;
  wire [3:0] ovs_mid  = dbl ? `UCG_MID_DBL : `UCG_MID_NORM;
  wire [3:0] nbits = ctb_ff[`UCG_CTB_SZMSB] ? `UCG_NBITS_MAX :
                     `UCG_NBITS_BASE + {2'h0, ctc_ff[`UCG_CTC_SZ_HI:`UCG_CTC_SZ_LO]};
  wire pen   = ctc_ff[`UCG_CTC_PEN];
  wire podd  = ctc_ff[`UCG_CTC_PODD];
  wire pol   = ctc_ff[`UCG_CTC_POL];
  wire tx_en = ctb_ff[`UCG_CTB_TXEN];
  wire rx_en = ctb_ff[`UCG_CTB_RXEN];

  // ---------------------------------------------
  // Baud generator
  // ---------------------------------------------
  wire baud_tick = (baud_cnt_ff == 12'h000) & ~is_slave;

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      baud_cnt_ff <= 12'h000;
    end else if (wr_bdl) begin
      baud_cnt_ff <= {bdh_ff, wd[7:0]};
    end else if (baud_cnt_ff == 12'h000) begin
      baud_cnt_ff <= {bdh_ff, bdl_ff};
    end else begin
      baud_cnt_ff <= baud_cnt_ff - 12'h001;
    end
  end

  // ---------------------------------------------
  // Transfer clock edges
  // ---------------------------------------------
  wire m_rise = baud_tick & ~xck_ff;
  wire m_fall = baud_tick & xck_ff;
  wire s_rise = xs2_ff & ~xs3_ff;
  wire s_fall = ~xs2_ff & xs3_ff;
  wire k_rise = is_master ? m_rise : (is_slave & s_rise);
  wire k_fall = is_master ? m_fall : (is_slave & s_fall);
  wire k_chg  = pol ? k_fall : k_rise;
  wire k_smp  = pol ? k_rise : k_fall;

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xck_ff    <= 1'b0;
      xck_oe_ff <= 1'b0;
      xs1_ff    <= 1'b0;
      xs2_ff    <= 1'b0;
      xs3_ff    <= 1'b0;
    end else begin
      xck_oe_ff <= is_master;
      if (!is_master) begin
        xck_ff <= 1'b0;
      end else if (baud_tick) begin
        xck_ff <= ~xck_ff;
      end
      xs1_ff <= xfer_clock_pin_in & is_slave;
      xs2_ff <= xs1_ff;
      xs3_ff <= xs2_ff;
    end
  end

  // ---------------------------------------------
  // Transmitter
  // ---------------------------------------------
  wire tx_abit   = baud_tick & (tx_div_ff == ovs_last);
  wire tx_strobe = is_sync ? k_chg : tx_abit;
  reg  [12:0] tx_frame;
  reg  [3:0]  tx_len;

  always @* begin
    tx_frame = 13'h1fff << (nbits + 4'h1);
    tx_frame = tx_frame | {3'h0, tx_buf_ff & ~(9'h1ff << nbits), 1'b0};
    if (pen) begin
      tx_frame[nbits + 4'h1] = ucg_parity(tx_buf_ff, nbits, podd);
    end
    tx_len = 4'h1 + nbits + {3'h0, pen} + (ctc_ff[`UCG_CTC_STOP2] ? 4'h2 : 4'h1);
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_div_ff  <= 4'h0;
      tx_buf_ff  <= 9'h000;
      tx_full_ff <= 1'b0;
      tx_sh_ff   <= 13'h1fff;
      tx_left_ff <= 4'h0;
      tx_busy_ff <= 1'b0;
      txd_ff     <= 1'b1;
      txc_ff     <= 1'b0;
    end else begin
      if (baud_tick) begin
        tx_div_ff <= (tx_div_ff >= ovs_last) ? 4'h0 : tx_div_ff + 4'h1;
      end
      if (wr_dat && !tx_full_ff) begin
        tx_buf_ff  <= {ctb_ff[`UCG_CTB_TXB8], wd[7:0]};
        tx_full_ff <= 1'b1;
      end
      if (wr && a == `UCG_OFF_STA && wd[`UCG_STA_TXC]) begin
        txc_ff <= 1'b0;
      end
      if (!tx_en) begin
        txd_ff     <= 1'b1;
        tx_left_ff <= 4'h0;
        tx_busy_ff <= 1'b0;
      end else if (tx_strobe) begin
        if (tx_left_ff != 4'h0) begin
          txd_ff     <= tx_sh_ff[0];
          tx_sh_ff   <= {1'b1, tx_sh_ff[12:1]};
          tx_left_ff <= tx_left_ff - 4'h1;
        end else if (tx_full_ff) begin
          txd_ff     <= tx_frame[0];
          tx_sh_ff   <= {1'b1, tx_frame[12:1]};
          tx_left_ff <= tx_len - 4'h1;
          tx_full_ff <= 1'b0;
          tx_busy_ff <= 1'b1;
        end else begin
          txd_ff <= 1'b1;
          if (tx_busy_ff) begin
            tx_busy_ff <= 1'b0;
            txc_ff     <= 1'b1;
          end
        end
      end
    end
  end

  // ---------------------------------------------
  // Receiver
  // ---------------------------------------------
  wire rx_bit  = is_sync ? k_smp : (baud_tick & (rx_ph_ff == ovs_last));
  wire [1:0] fifo_cap = ctc_ff[`UCG_CTC_COMPAT] ? `UCG_FIFO_CAP_C : `UCG_FIFO_CAP;
  wire room    = fifo_cnt_ff < fifo_cap;
  wire push    = hold_v_ff & room;
  wire pop     = rd_dat & (fifo_cnt_ff != 2'h0);
  reg  start_ev;

  always @* begin
    start_ev = 1'b0;
    if (rx_en && rx_st_ff == RX_IDLE) begin
      if (is_sync) begin
        start_ev = k_smp & ~rxd_in;
      end else begin
        start_ev = baud_tick & ~rxd_in & (rx_ph_ff == ovs_mid);
      end
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_ff    <= RX_IDLE;
      rx_ph_ff    <= 4'h0;
      rx_cnt_ff   <= 4'h0;
      rx_sh_ff    <= 9'h000;
      rx_perr_ff  <= 1'b0;
      hold_ff     <= 11'h000;
      hold_v_ff   <= 1'b0;
      ovr_pend_ff <= 1'b0;
    end else begin
      if (push) begin
        hold_v_ff   <= 1'b0;
        ovr_pend_ff <= 1'b0;
      end else if (start_ev && hold_v_ff) begin
        hold_v_ff   <= 1'b0;
        ovr_pend_ff <= 1'b1;
      end
      if (!rx_en) begin
        rx_st_ff <= RX_IDLE;
        rx_ph_ff <= 4'h0;
      end else begin
        case (rx_st_ff)
          RX_IDLE: begin
            if (start_ev) begin
              rx_st_ff  <= RX_DATA;
              rx_ph_ff  <= 4'h0;
              rx_cnt_ff <= 4'h0;
            end else if (!is_sync && baud_tick) begin
              rx_ph_ff <= rxd_in ? 4'h0 : rx_ph_ff + 4'h1;
            end
          end
          RX_DATA: begin
            if (rx_bit) begin
              rx_sh_ff  <= {rxd_in, rx_sh_ff[8:1]};
              rx_cnt_ff <= rx_cnt_ff + 4'h1;
              if (rx_cnt_ff == nbits - 4'h1) begin
                rx_st_ff <= pen ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR: begin
            if (rx_bit) begin
              rx_perr_ff <= rxd_in ^ ucg_parity(rx_sh_ff >> (`UCG_NBITS_MAX - nbits),
                                                nbits, podd);
              rx_st_ff   <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_bit) begin
              hold_ff    <= {~rxd_in, rx_perr_ff & pen,
                             rx_sh_ff >> (`UCG_NBITS_MAX - nbits)};
              hold_v_ff  <= 1'b1;
              rx_perr_ff <= 1'b0;
              rx_st_ff   <= RX_IDLE;
            end
          end
          default: begin
            rx_st_ff <= RX_IDLE;
          end
        endcase
        if (rx_st_ff != RX_IDLE && !is_sync && baud_tick) begin
          rx_ph_ff <= (rx_ph_ff >= ovs_last) ? 4'h0 : rx_ph_ff + 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------
  // Receive FIFO
  // ---------------------------------------------
  wire [11:0] head = fifo_mem[rd_ptr_ff];

  always @(posedge mclk_in) begin
    if (push) begin
      fifo_mem[wr_ptr_ff] <= {ovr_pend_ff, hold_ff};
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff   <= 1'b0;
      rd_ptr_ff   <= 1'b0;
      fifo_cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        fifo_cnt_ff <= fifo_cnt_ff + 2'h1;
      end else if (pop && !push) begin
        fifo_cnt_ff <= fifo_cnt_ff - 2'h1;
      end
    end
  end

  // ---------------------------------------------
  // Register file and bus slave
  // ---------------------------------------------
  wire        rx_any = fifo_cnt_ff != 2'h0;
  reg  [31:0] rmux;

  always @* begin
    rmux = 32'h0000_0000;
    if (a == `UCG_OFF_DATA) begin
      rmux[7:0] = rx_any ? head[7:0] : 8'h00;
    end else if (a == `UCG_OFF_STA) begin
      rmux[`UCG_STA_RXC]  = rx_any;
      rmux[`UCG_STA_TXC]  = txc_ff;
      rmux[`UCG_STA_TXE]  = ~tx_full_ff;
      rmux[`UCG_STA_FE]   = rx_any & head[10];
      rmux[`UCG_STA_OVR]  = rx_any & head[11];
      rmux[`UCG_STA_PERR] = rx_any & head[9];
      rmux[`UCG_STA_DS]   = ds_ff;
    end else if (a == `UCG_OFF_CTB) begin
      rmux[7:0] = ctb_ff;
      rmux[`UCG_CTB_RX_NINTH_BIT] = rx_any & head[8];
    end else if (a == `UCG_OFF_CTC) begin
      rmux[9:0] = ctc_ff;
    end else if (a == `UCG_OFF_BDL) begin
      rmux[7:0] = bdl_ff;
    end else if (a == `UCG_OFF_BDH) begin
      rmux[3:0] = bdh_ff;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      ctb_ff   <= 8'h00;
      ctc_ff   <= `UCG_CTC_RST;
      ds_ff    <= 1'b0;
      bdl_ff   <= 8'h00;
      bdh_ff   <= 4'h0;
    end else begin
      wait_ff <= ~(req & wait_ff);
      if (req && wait_ff) begin
        rdata_ff <= rmux;
      end
      if (wr) begin
        if (a == `UCG_OFF_STA) begin
          ds_ff <= wd[`UCG_STA_DS];
        end else if (a == `UCG_OFF_CTB) begin
          ctb_ff <= wd[7:0] & ~(8'h01 << `UCG_CTB_RX_NINTH_BIT);
        end else if (a == `UCG_OFF_CTC) begin
          ctc_ff <= wd[9:0];
        end else if (a == `UCG_OFF_BDL) begin
          bdl_ff <= wd[7:0];
        end else if (a == `UCG_OFF_BDH) begin
          bdh_ff <= wd[3:0];
        end
      end
    end
  end

  // ---------------------------------------------
  // Interrupt requests
  // ---------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_rx_ff  <= 1'b0;
      irq_txe_ff <= 1'b0;
      irq_txc_ff <= 1'b0;
    end else begin
      irq_rx_ff  <= rx_any & ctb_ff[`UCG_CTB_RXIE];
      irq_txe_ff <= ~tx_full_ff & ctb_ff[`UCG_CTB_TXEIE];
      irq_txc_ff <= txc_ff & ctb_ff[`UCG_CTB_TXCIE];
    end
  end

  assign avs_readdata_out      = rdata_ff;
  assign avs_waitrequest_out   = wait_ff;
  assign txd_out               = txd_ff;
  assign xfer_clock_pin_out    = xck_ff;
  assign xfer_clock_pin_oe_out = xck_oe_ff;
  assign rx_done_irq_out       = irq_rx_ff;
  assign tx_empty_irq_out      = irq_txe_ff;
  assign tx_done_irq_out       = irq_txc_ff;

endmodule // ucg_core

`default_nettype wire

// *** tb/ucg_core_chk.sv ***
// Port-level assertion checker for the serial clock and buffer core
`timescale 1ns/1ns
`default_nettype none
module ucg_chk (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        txd_out,
  input wire logic        xfer_clock_pin_out,
  input wire logic        xfer_clock_pin_oe_out,
  input wire logic        rx_done_irq_out,
  input wire logic        tx_done_irq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic req;
  assign req = avs_read_in || avs_write_in;
  // ---------------------------------------------
  // Register bus handshake
  // ---------------------------------------------
  wait_answer_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered next cycle");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  rdata_hold_a: assert property ($changed(avs_readdata_out) |-> !avs_waitrequest_out)
    else $error("read data changed outside an answer");
  // ---------------------------------------------
  // Pins and events
  // ---------------------------------------------
  reset_vals_a: assert property ($rose(rst_n_in) |-> avs_waitrequest_out && txd_out
    && !xfer_clock_pin_oe_out && !xfer_clock_pin_out && !rx_done_irq_out && !tx_done_irq_out)
    else $error("outputs not at reset values");
  xck_idle_a: assert property (!xfer_clock_pin_oe_out && $past(!xfer_clock_pin_oe_out) |-> !xfer_clock_pin_out)
    else $error("transfer clock driven while not master");
  xck_still_a: assert property ($changed(xfer_clock_pin_out) |-> xfer_clock_pin_oe_out || $past(xfer_clock_pin_oe_out))
    else $error("transfer clock toggles outside master mode");
  start_len_a: assert property ($fell(txd_out) |=> !txd_out)
    else $error("start bit shorter than two cycles");
  rx_irq_fall_a: assert property ($fell(rx_done_irq_out) |->
    $past(req, 1) || $past(req, 2) || $past(req, 3) || $past(req, 4))
    else $error("receive request dropped without an access");
  txc_fall_a: assert property ($fell(tx_done_irq_out) |->
    $past(req, 1) || $past(req, 2) || $past(req, 3) || $past(req, 4))
    else $error("transmit done request dropped without an access");
  read_c: cover property (avs_read_in && !avs_waitrequest_out);
  master_c: cover property ($rose(xfer_clock_pin_oe_out));
  frame_c: cover property ($fell(txd_out));
endmodule // ucg_chk

bind ucg_core ucg_chk ucg_chk_i (.mclk_in, .rst_n_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
  .avs_waitrequest_out, .txd_out, .xfer_clock_pin_out, .xfer_clock_pin_oe_out, .rx_done_irq_out,
  .tx_done_irq_out);
`default_nettype wire

// *** tb/ucg_peer.sv ***
// Remote serial peer: asynchronous frames and peer-clocked slave exchanges
`timescale 1ns/1ns
`default_nettype none
module ucg_peer (
  input  wire logic clk_in,
  input  wire logic txd_in,
  output var  logic rxd_out,
  output var  logic xck_out
);
  int cyc = 0;
  initial begin
    rxd_out = 1'b1;
    xck_out = 1'b0;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
  end
  // ---------------------------------------------
  // Start, eight bits LSB first, one stop
  // ---------------------------------------------
  task automatic send(input logic [7:0] d, input logic stp, input int cpb);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      rxd_out <= f[i];
      repeat (cpb * 3 / 4) @(posedge clk_in);
      // Bad stop releases the line past the sample point
      rxd_out <= (i == 9) ? 1'b1 : f[i];
      repeat (cpb / 4 - 1) @(posedge clk_in);
    end
    repeat (cpb) @(posedge clk_in);
  endtask
  task automatic recv(input int cpb, output logic [7:0] d, output int t0);
    int n;
    n = 0;
    while (txd_in !== 1'b0 && n < 5000) begin
      @(posedge clk_in);
      n++;
    end
    t0 = cyc;
    repeat (cpb / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (cpb) @(posedge clk_in);
      d[i] = txd_in;
    end
    repeat (cpb) @(posedge clk_in);
  endtask
  // ---------------------------------------------
  // Slave exchange, clock period of eight cycles
  // ---------------------------------------------
  task automatic xfer(input logic [7:0] d, output logic [9:0] q);
    logic [10:0] f, g;
    f = {2'b11, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_in);
      xck_out <= 1'b1;
      rxd_out <= f[i];
      repeat (4) @(posedge clk_in);
      xck_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      g[i] = txd_in;
      @(posedge clk_in);
    end
    q = g[9:0];
  endtask
endmodule // ucg_peer
`default_nettype wire

// *** tb/tb_ucg_core.sv ***
// Testbench for the serial clock and buffer core
`timescale 1ns/1ns
`default_nettype none
module tb_ucg_core;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [4:0]  avs_address_in = 5'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  wire logic [31:0] avs_readdata_out;
  wire logic   avs_waitrequest_out, rxd_in, txd_out, xck_in, xck_out, xck_oe, rx_irq, txe_irq, txc_irq;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  vals [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  always #2 mclk_in = ~mclk_in;
  ucg_core ucg_core_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .rxd_in(rxd_in),
    .txd_out(txd_out), .xfer_clock_pin_in(xck_in), .xfer_clock_pin_out(xck_out),
    .xfer_clock_pin_oe_out(xck_oe), .rx_done_irq_out(rx_irq), .tx_empty_irq_out(txe_irq),
    .tx_done_irq_out(txc_irq));
  ucg_peer ucg_peer_i (.clk_in(mclk_in), .txd_in(txd_out), .rxd_out(rxd_in), .xck_out(xck_in));
  // ---------------------------------------------
  // Bus, compare and closing tasks
  // ---------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 64);
    if (n >= 64) num_errors++;
    q = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask
  task automatic poll(input int b);
    logic [31:0] q;
    int n;
    n = 0;
    q = '0;
    while (q[b] !== 1'b1 && n < 400) begin
      bus(1'b0, 5'h04, 32'h0, q);
      n++;
    end
    if (n >= 400) num_errors++;
  endtask
  // Two frames back to back, then clear tx complete
  task automatic txpair(input int cpb, input logic [31:0] st);
    logic [7:0] d0, d1;
    int t0, t1;
    fork
      begin
        ucg_peer_i.recv(cpb, d0, t0);
        ucg_peer_i.recv(cpb, d1, t1);
      end
      begin
        wr(5'h00, 32'ha5);
        poll(5);
        wr(5'h00, 32'h3c);
      end
    join
    chk("tx byte 0", 32'ha5, d0);
    chk("tx byte 1", 32'h3c, d1);
    chk("frame spacing", 10 * cpb, t1 - t0);
    poll(6);
    chk("tx done irq", 32'h1, txc_irq);
    wr(5'h04, st);
    rd("tx done clear", 5'h04, 32'h40, 32'h0);
    chk("tx done irq off", 32'h0, txc_irq);
  endtask
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    logic x;
    logic [7:0] d8;
    logic [9:0] q10;
    int n, kk, t8;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd("ctrl c reset", 5'h0c, 32'h3ff, 32'h006);
    rd("status reset", 5'h04, 32'hff, 32'h20);
    rd("unmapped", 5'h18, 32'hffffffff, 32'h0);
    wr(5'h14, 32'h0);
    wr(5'h10, 32'h01);
    wr(5'h08, 32'hd8);
    txpair(32, 32'h40);
    wr(5'h04, 32'h02);
    txpair(16, 32'h42);
    wr(5'h04, 32'h0);
    for (int dd = 2; dd >= 1; dd--) begin
      wr(5'h0c, (dd == 2) ? 32'h006 : 32'h106);
      for (int i = 0; i < dd + 2; i++) ucg_peer_i.send(vals[i], i != 1, 32);
      chk("rx irq", 32'h1, rx_irq);
      for (int k = 0; k <= dd; k++) begin
        kk = (k < dd) ? k : dd + 1;
        rd("rx status", 5'h04, 32'h98, {24'h0, 1'b1, 2'b0, kk == 1, k == dd, 3'b0});
        rd("rx data", 5'h00, 32'hff, {24'h0, vals[kk]});
      end
      rd("rx empty", 5'h04, 32'h80, 32'h0);
      chk("rx irq off", 32'h0, rx_irq);
    end
    wr(5'h0c, 32'h246);
    wr(5'h00, 32'h5a);
    chk("xck enable", 32'h1, xck_oe);
    ucg_peer_i.recv(4, d8, t8);
    chk("master tx byte", 32'h5a, d8);
    for (int j = 0; j < 2; j++) begin
      x = xck_out;
      n = 0;
      while (xck_out === x && n < 100) begin
        @(posedge mclk_in);
        n++;
      end
    end
    chk("xck half period", 32'h2, n);
    poll(6);
    wr(5'h0c, 32'h006);
    rd("ctrl c async", 5'h0c, 32'h3ff, 32'h006);
    chk("xck released", 32'h0, {xck_oe, xck_out});
    // Slave exchange clocked by the peer
    wr(5'h08, 32'hf8);
    wr(5'h04, 32'h40);
    chk("tx empty irq", 32'h1, txe_irq);
    wr(5'h0c, 32'h046);
    wr(5'h00, 32'h69);
    rd("slave no clock", 5'h04, 32'h60, 32'h0);
    chk("tx empty irq off", 32'h0, txe_irq);
    ucg_peer_i.xfer(8'h96, q10);
    chk("slave tx frame", 32'h2d2, q10);
    chk("slave xck input", 32'h0, {xck_oe, xck_out});
    rd("slave status", 5'h04, 32'hf8, 32'he0);
    rd("slave rx data", 5'h00, 32'hff, 32'h96);
    end_of_test();
  end
endmodule // tb_ucg_core
`default_nettype wire
